// ### core/mac_branch_defines.svh
// Constants for the multiply, divide and branch execution block
`ifndef MAC_BRANCH_DEFINES_SVH
`define MAC_BRANCH_DEFINES_SVH

// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define OP_SIGNED_MUL 6'h11
`define OP_SIGNED_MUL_NOWB 6'h12
`define OP_SIGNED_MAC_NOWB 6'h14
`define OP_UDIV 6'h15
`define OP_ABS_BRANCH 6'h34
`define OP_REL_BRANCH 6'h35

// ----------------------------------------------------------------
// Condition field bits
// ----------------------------------------------------------------
`define CC_Z_CLEAR 0
`define CC_Z_SET 1
`define CC_SEL_CLEAR 2
`define CC_SEL_SET 3
`define CC_SEL_NEG 4

// ----------------------------------------------------------------
// Timing, counted in clock edges after the operand read edge
// ----------------------------------------------------------------
`define DIV_STEPS 5'h10
`define DIV_BITS_PER_STEP 2

// ----------------------------------------------------------------
// APB register map
// ----------------------------------------------------------------
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_ACC 4'h8
`define CTRL_EN_BIT 0
`define CTRL_RESET 1'h1
`define ST_BUSY 0
`define ST_Z 1
`define ST_N 2
`define ST_C 3
`define ST_MAC_PEND 4
`define ST_EXT_JUMP 5

`endif

// ### core/mac_branch_pkg.sv
// Types for the multiply, divide and branch execution block
package mac_branch_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MUL,
    ST_DIV,
    ST_REL
  } exec_state_t;

endpackage

// ### core/mac_branch_exec.sv
// Multiply, multiply-accumulate, divide and branch execution unit with APB status
//
// Behaviour
// - Divide writes quotient at cycle 18
// - Unsigned 32-bit divide, flags kept
// - Signed 16x16 multiply into destination
// - Multiply flags: zero, negative, original bit31
// - Multiply reads cycle 1, writes cycle 3
// - No-writeback multiply sets flags and accumulator only
// - MAC adds product to accumulator
// - Write of the next instruction after MAC, or an outside write before it issues, takes accumulator
// - MAC and nowb multiply read cycle 1
// - Relative target: next address plus offset
// - Relative branch shares condition, keeps flags
// - Relative branch one cycle slower
// - Branches reliable only from internal RAM
// - Absolute branch to source register address
// - Condition bits ANDed over zero, N/C
`include "mac_branch_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module mac_branch_exec (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic issue_valid,
  input wire logic [5:0] issue_opcode,
  input wire logic [4:0] src_field,
  input wire logic [4:0] dst_field,
  input wire logic [31:0] src_val,
  input wire logic [31:0] dst_val,
  input wire logic [31:0] next_pc,
  input wire logic fetch_internal,
  input wire logic arith_valid,
  input wire logic [31:0] arith_result,
  input wire logic arith_z,
  input wire logic arith_n,
  input wire logic arith_c,
  input wire logic ext_wr_valid,
  input wire logic [4:0] ext_wr_addr,
  input wire logic [31:0] ext_wr_data,
  output logic issue_ready,
  output logic reg_we,
  output logic [4:0] reg_waddr,
  output logic [31:0] reg_wdata,
  output logic flag_z,
  output logic flag_n,
  output logic flag_c,
  output logic branch_taken,
  output logic [31:0] branch_target
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  mac_branch_pkg::exec_state_t state_q;
  logic [4:0] cnt_q;
  logic [5:0] op_q;
  logic [4:0] dst_idx_q;
  logic [31:0] prod_q;
  logic orig_b31_q;
  logic [31:0] acc_q;
  logic mac_pend_q;
  logic op_pend_q;
  logic [31:0] rem_q;
  logic [31:0] quo_q;
  logic [31:0] dvs_q;
  logic [31:0] rel_target_q;
  logic rel_cond_q;
  logic en_q;
  logic ext_jump_q;

  logic accept;
  logic [31:0] product;
  logic cond_ok;
  logic sel_flag;
  logic [31:0] rel_target;
  logic [31:0] rem_n;
  logic [31:0] quo_n;
  logic [32:0] trial;
  logic div_last;
  mac_branch_pkg::exec_state_t state_d;

  assign accept = issue_valid && issue_ready;
  assign product = 32'($signed(src_val[15:0]) * $signed(dst_val[15:0]));
  assign div_last = (state_q == mac_branch_pkg::ST_DIV) && (cnt_q == `DIV_STEPS);

  // ----------------------------------------------------------------
  // Condition and relative target
  // ----------------------------------------------------------------
  // ANDed condition test
  always_comb begin
    sel_flag = dst_field[`CC_SEL_NEG] ? flag_n : flag_c;
    cond_ok = 1'b1;
    if (dst_field[`CC_Z_CLEAR] && flag_z) begin
      cond_ok = 1'b0;
    end
    if (dst_field[`CC_Z_SET] && !flag_z) begin
      cond_ok = 1'b0;
    end
    if (dst_field[`CC_SEL_CLEAR] && sel_flag) begin
      cond_ok = 1'b0;
    end
    if (dst_field[`CC_SEL_SET] && !sel_flag) begin
      cond_ok = 1'b0;
    end
  end

  // Halfword offset, sign extended, scaled to bytes
  assign rel_target = next_pc + {{26{src_field[4]}}, src_field, 1'b0};

  // ----------------------------------------------------------------
  // Divider: two restoring steps per clock
  // ----------------------------------------------------------------
  // Unsigned restoring division
  always_comb begin
    rem_n = rem_q;
    quo_n = quo_q;
    trial = 33'h0;
    for (int i = 0; i < `DIV_BITS_PER_STEP; i++) begin
      trial = {rem_n, quo_n[31]} - {1'b0, dvs_q};
      if (!trial[32]) begin
        rem_n = trial[31:0];
        quo_n = {quo_n[30:0], 1'b1};
      end else begin
        rem_n = {rem_n[30:0], quo_n[31]};
        quo_n = {quo_n[30:0], 1'b0};
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      mac_branch_pkg::ST_IDLE: begin
        if (accept) begin
          unique case (issue_opcode)
            `OP_SIGNED_MUL, `OP_SIGNED_MUL_NOWB, `OP_SIGNED_MAC_NOWB: begin
              state_d = mac_branch_pkg::ST_MUL;
            end
            `OP_UDIV: begin
              state_d = mac_branch_pkg::ST_DIV;
            end
            `OP_REL_BRANCH: begin
              state_d = mac_branch_pkg::ST_REL;
            end
            default: begin
              state_d = mac_branch_pkg::ST_IDLE;
            end
          endcase
        end
      end
      mac_branch_pkg::ST_MUL: begin
        state_d = mac_branch_pkg::ST_IDLE;
      end
      mac_branch_pkg::ST_DIV: begin
        if (div_last) begin
          state_d = mac_branch_pkg::ST_IDLE;
        end
      end
      mac_branch_pkg::ST_REL: begin
        state_d = mac_branch_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= mac_branch_pkg::ST_IDLE;
      issue_ready <= 1'b0;
    end else begin
      state_q <= state_d;
      issue_ready <= en_q && (state_d == mac_branch_pkg::ST_IDLE);
    end
  end

  // Operand capture on the read cycle
  // Operands read at cycle 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q <= 6'h00;
      dst_idx_q <= 5'h00;
      prod_q <= 32'h0;
      orig_b31_q <= 1'b0;
      op_pend_q <= 1'b0;
      rel_target_q <= 32'h0;
      rel_cond_q <= 1'b0;
    end else if (accept) begin
      op_q <= issue_opcode;
      dst_idx_q <= dst_field;
      prod_q <= product;
      orig_b31_q <= dst_val[31];
      op_pend_q <= mac_pend_q;
      rel_target_q <= rel_target;
      rel_cond_q <= cond_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 5'h00;
      rem_q <= 32'h0;
      quo_q <= 32'h0;
      dvs_q <= 32'h0;
    end else if (accept && issue_opcode == `OP_UDIV) begin
      cnt_q <= 5'h01;
      rem_q <= 32'h0;
      quo_q <= dst_val;
      dvs_q <= src_val;
    end else if (state_q == mac_branch_pkg::ST_DIV) begin
      cnt_q <= cnt_q + 5'h01;
      rem_q <= rem_n;
      quo_q <= quo_n;
    end
  end

  // ----------------------------------------------------------------
  // Accumulator and hand-off flag
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= 32'h0;
    end else if (state_q == mac_branch_pkg::ST_MUL) begin
      if (op_q == `OP_SIGNED_MAC_NOWB) begin
        acc_q <= acc_q + prod_q;
      end else begin
        acc_q <= prod_q;
      end
    end else if (arith_valid) begin
      acc_q <= arith_result;
    end
  end

  // Pending until the very next instruction is issued or an outside write arrives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mac_pend_q <= 1'b0;
    end else if (accept) begin
      mac_pend_q <= (issue_opcode == `OP_SIGNED_MAC_NOWB);
    end else if (ext_wr_valid) begin
      mac_pend_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register write port
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_we <= 1'b0;
      reg_waddr <= 5'h00;
      reg_wdata <= 32'h0;
    end else if (state_q == mac_branch_pkg::ST_MUL && op_q == `OP_SIGNED_MUL) begin
      // Product lands at cycle 3; unless after a MAC
      reg_we <= 1'b1;
      reg_waddr <= dst_idx_q;
      reg_wdata <= op_pend_q ? acc_q : prod_q;
    end else if (div_last) begin
      // Quotient lands at cycle 18; same hand-off
      reg_we <= 1'b1;
      reg_waddr <= dst_idx_q;
      reg_wdata <= op_pend_q ? acc_q : quo_n;
    end else if (ext_wr_valid) begin
      reg_we <= 1'b1;
      reg_waddr <= ext_wr_addr;
      reg_wdata <= mac_pend_q ? acc_q : ext_wr_data;
    end else begin
      reg_we <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  // Divide, MAC and both branches leave the flags alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_z <= 1'b0;
      flag_n <= 1'b0;
      flag_c <= 1'b0;
    end else if (state_q == mac_branch_pkg::ST_MUL && op_q != `OP_SIGNED_MAC_NOWB) begin
      // Product flags, carry from old bit 31
      flag_z <= (prod_q == 32'h0);
      flag_n <= prod_q[31];
      flag_c <= orig_b31_q;
    end else if (arith_valid) begin
      flag_z <= arith_z;
      flag_n <= arith_n;
      flag_c <= arith_c;
    end
  end

  // ----------------------------------------------------------------
  // Branch outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      branch_taken <= 1'b0;
      branch_target <= 32'h0;
    end else if (accept && issue_opcode == `OP_ABS_BRANCH) begin
      // Absolute target from source; untaken falls through
      branch_taken <= cond_ok;
      branch_target <= src_val;
    end else if (state_q == mac_branch_pkg::ST_REL) begin
      branch_taken <= rel_cond_q;
      branch_target <= rel_target_q;
    end else begin
      branch_taken <= 1'b0;
    end
  end

  // External-memory branches still run, but software is told
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_jump_q <= 1'b0;
    end else if (accept && !fetch_internal &&
                 (issue_opcode == `OP_ABS_BRANCH || issue_opcode == `OP_REL_BRANCH)) begin
      ext_jump_q <= 1'b1;
    end else if (psel && penable && pready && pwrite &&
                 paddr == {28'h0, `REG_STATUS} && pwdata[`ST_EXT_JUMP]) begin
      ext_jump_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic mapped;
  logic [31:0] rd_mux;

  assign mapped = (paddr[31:4] == 28'h0) &&
                  (paddr[3:0] == `REG_CTRL || paddr[3:0] == `REG_STATUS ||
                   paddr[3:0] == `REG_ACC);

  always_comb begin
    rd_mux = 32'h0;
    unique case (paddr[3:0])
      `REG_CTRL: begin
        rd_mux[`CTRL_EN_BIT] = en_q;
      end
      `REG_STATUS: begin
        rd_mux[`ST_BUSY] = (state_q != mac_branch_pkg::ST_IDLE);
        rd_mux[`ST_Z] = flag_z;
        rd_mux[`ST_N] = flag_n;
        rd_mux[`ST_C] = flag_c;
        rd_mux[`ST_MAC_PEND] = mac_pend_q;
        rd_mux[`ST_EXT_JUMP] = ext_jump_q;
      end
      `REG_ACC: begin
        rd_mux = acc_q;
      end
      default: begin
        rd_mux = 32'h0;
      end
    endcase
  end

  // One wait-free access phase: ready is raised at the end of setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= !mapped;
      prdata <= (mapped && !pwrite) ? rd_mux : 32'h0;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= `CTRL_RESET;
    end else if (psel && penable && pready && pwrite && paddr == {28'h0, `REG_CTRL}) begin
      en_q <= pwdata[`CTRL_EN_BIT];
    end
  end

endmodule

`default_nettype wire

// ### test/mac_branch_exec_monitor.sv
// Assertion checker bound to the execution block
`timescale 1ns/1ps
`default_nettype none
`include "mac_branch_defines.svh"
module mac_branch_exec_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic issue_valid,
  input wire logic issue_ready,
  input wire logic [5:0] issue_opcode,
  input wire logic [4:0] src_field,
  input wire logic [4:0] dst_field,
  input wire logic [31:0] src_val,
  input wire logic [31:0] dst_val,
  input wire logic [31:0] next_pc,
  input wire logic reg_we,
  input wire logic [4:0] reg_waddr,
  input wire logic flag_z,
  input wire logic flag_n,
  input wire logic flag_c,
  input wire logic branch_taken,
  input wire logic [31:0] branch_target
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic go = issue_valid && issue_ready;
  wire logic dst_top = dst_val[31];
  wire logic lo_zero = src_val[15:0] == 16'h0000 || dst_val[15:0] == 16'h0000;
  // ------
  // Execution timing and results
  // ------
  // product write edge
  property p_mul_wr;
    go && issue_opcode == `OP_SIGNED_MUL |-> ##2 reg_we && reg_waddr == $past(dst_field, 2);
  endproperty
  a_mul_wr: assert property (p_mul_wr) else $error("multiply write misplaced");
  property p_mul_c;
    go && issue_opcode == `OP_SIGNED_MUL |-> ##2 flag_c == $past(dst_top, 2);
  endproperty
  a_mul_c: assert property (p_mul_c) else $error("multiply carry wrong");
  property p_nowb;
    go && issue_opcode == `OP_SIGNED_MUL_NOWB |-> ##2 !reg_we && flag_z == $past(lo_zero, 2);
  endproperty
  a_nowb: assert property (p_nowb) else $error("no-writeback multiply wrong");
  property p_div_wr;
    go && issue_opcode == `OP_UDIV |-> ##17 reg_we && reg_waddr == $past(dst_field, 17);
  endproperty
  a_div_wr: assert property (p_div_wr) else $error("divide write misplaced");
  property p_div_flags;
    go && issue_opcode == `OP_UDIV |=> (!issue_ready && $stable({flag_z, flag_n, flag_c}))[*8];
  endproperty
  a_div_flags: assert property (p_div_flags) else $error("divide disturbed flags");
  property p_rel;
    go && issue_opcode == `OP_REL_BRANCH && dst_field == 5'h00 |-> ##1 !branch_taken ##1
      branch_taken && branch_target == $past(next_pc, 2) + 32'($signed({$past(src_field, 2), 1'b0}));
  endproperty
  a_rel: assert property (p_rel) else $error("relative branch wrong");
  property p_untaken;
    go && issue_opcode == `OP_REL_BRANCH && dst_field == 5'h02 && !flag_z |=> (!branch_taken)[*3];
  endproperty
  a_untaken: assert property (p_untaken) else $error("branch taken on false condition");
  property p_abs;
    go && issue_opcode == `OP_ABS_BRANCH && dst_field == 5'h00 |=> branch_taken && branch_target == $past(src_val);
  endproperty
  a_abs: assert property (p_abs) else $error("absolute branch wrong");
endmodule
bind mac_branch_exec mac_branch_exec_monitor mac_branch_exec_monitor_inst (.pclk, .presetn,
  .issue_valid, .issue_ready, .issue_opcode, .src_field, .dst_field, .src_val, .dst_val,
  .next_pc, .reg_we, .reg_waddr, .flag_z, .flag_n, .flag_c, .branch_taken, .branch_target);
`default_nettype wire

// ### test/testbench.sv
// Self-checking bench for the execution block
`timescale 1ns/1ps
`default_nettype none
`include "mac_branch_defines.svh"
module testbench;
  logic pclk, presetn, psel, penable, pwrite, iv, fi, av, az, an, ac, er, ew;
  logic [4:0] ewa;
  logic [31:0] ewd;
  logic pready, pslverr, issue_ready, reg_we, flag_z, flag_n, flag_c, branch_taken;
  logic [31:0] paddr, pwdata, prdata, sv, dv, npc, ares, reg_wdata, branch_target, rd;
  logic [5:0] opc;
  logic [4:0] sf, df, reg_waddr;
  logic [8:0] tbl [9];
  int bad_count, checks_done, n, i;
  mac_branch_exec mac_branch_exec_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .issue_valid(iv), .issue_opcode(opc),
    .src_field(sf), .dst_field(df), .src_val(sv), .dst_val(dv), .next_pc(npc),
    .fetch_internal(fi), .arith_valid(av), .arith_result(ares), .arith_z(az), .arith_n(an),
    .arith_c(ac), .ext_wr_valid(ew), .ext_wr_addr(ewa), .ext_wr_data(ewd),
    .issue_ready, .reg_we, .reg_waddr, .reg_wdata, .flag_z, .flag_n, .flag_c,
    .branch_taken, .branch_target);
  wire logic [31:0] flags = {29'h0, flag_z, flag_n, flag_c};
  // ------
  // Shared tasks
  // ------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic issue(input logic [5:0] o, input logic [4:0] s, input logic [4:0] d,
                       input logic [31:0] a, input logic [31:0] b);
    @(posedge pclk);
    {iv, opc, sf, df, sv, dv} <= {1'b1, o, s, d, a, b};
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (issue_ready !== 1'b1 && n < 50);
    iv <= 1'b0;
  endtask
  // Counts edges after the take edge; 24 means nothing came
  task automatic wait_ev(input logic br);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((br ? branch_taken : reg_we) !== 1'b1 && n < 24);
  endtask
  task automatic arith(input logic [31:0] r, input logic [2:0] f);
    @(posedge pclk);
    {av, ares, az, an, ac} <= {1'b1, r, f};
    @(posedge pclk);
    av <= 1'b0;
  endtask
  // Outside register write, then one edge so the routed write can be seen
  task automatic ext_wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge pclk);
    {ew, ewa, ewd} <= {1'b1, a, d};
    @(posedge pclk);
    ew <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic test_done;
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ------
  // Clock, watchdog and tests
  // ------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    bad_count++;
    test_done;
  end
  initial begin
    {psel, penable, pwrite, iv, av, az, an, ac, paddr, pwdata, opc, sf, df, sv, dv, ares} = '0;
    {ew, ewa, ewd} = '0;
    // Branches sit on 4-byte aligned addresses
    {presetn, fi, npc, bad_count, checks_done} = {1'b0, 1'b1, 32'h00001000, 64'h0};
    // Entries: taken, z n c, condition field
    tbl = '{9'h100, 9'h081, 9'h182, 9'h002, 9'h054, 9'h158, 9'h008, 9'h105, 9'h009};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 32'h00000000, 32'h0);
    cmp(rd, 32'h00000001);
    apb(1'b0, 32'h00000004, 32'h0);
    cmp(rd, 32'h00000000);
    apb(1'b0, 32'h0000000c, 32'h0);
    cmp({er, rd[30:0]}, 32'h80000000);
    apb(1'b1, 32'h00000000, 32'h0);
    repeat (2) @(posedge pclk);
    cmp(issue_ready, 32'h0);
    apb(1'b1, 32'h00000000, 32'h1);
    issue(`OP_SIGNED_MUL, 5'h03, 5'h09, 32'h0000fffe, 32'h80000003);
    wait_ev(1'b0);
    cmp(n, 32'd2);
    cmp(reg_waddr, 32'h9);
    cmp(reg_wdata, 32'hfffffffa);
    cmp(flags, 32'h3);
    issue(`OP_SIGNED_MUL_NOWB, 5'h01, 5'h02, 32'h12340000, 32'h7fff5678);
    wait_ev(1'b0);
    cmp(n, 32'd24);
    cmp(flags, 32'h4);
    arith(32'd100, 3'b000);
    issue(`OP_SIGNED_MAC_NOWB, 5'h00, 5'h00, 32'h00000002, 32'hfffffffc);
    repeat (3) @(posedge pclk);
    apb(1'b0, 32'h00000008, 32'h0);
    cmp(rd, 32'd92);
    issue(`OP_SIGNED_MUL, 5'h00, 5'h04, 32'h2, 32'h3);
    wait_ev(1'b0);
    cmp(reg_waddr, 32'h4);
    cmp(reg_wdata, 32'd92);
    arith(32'h0, 3'b101);
    issue(`OP_UDIV, 5'h00, 5'h07, 32'd7, 32'd100);
    wait_ev(1'b0);
    cmp(n, 32'd17);
    cmp(reg_wdata, 32'd14);
    cmp(flags, 32'h5);
    for (i = 0; i < 9; i++) begin
      arith(32'h0, tbl[i][7:5]);
      issue(`OP_REL_BRANCH, i[0] ? 5'h10 : 5'h0f, tbl[i][4:0], 32'h0, 32'h0);
      wait_ev(1'b1);
      cmp(n, tbl[i][8] ? 32'd2 : 32'd24);
      if (tbl[i][8])
        cmp(branch_target, i[0] ? 32'h00000fe0 : 32'h0000101e);
      cmp(flags, {29'h0, tbl[i][7:5]});
    end
    fi <= 1'b0;
    issue(`OP_ABS_BRANCH, 5'h00, 5'h00, 32'h00002468, 32'h0);
    wait_ev(1'b1);
    fi <= 1'b1;
    cmp(n, 32'd1);
    cmp(branch_target, 32'h00002468);
    apb(1'b0, 32'h00000004, 32'h0);
    cmp(rd[5], 32'h1);
    apb(1'b1, 32'h00000004, 32'h00000020);
    apb(1'b0, 32'h00000004, 32'h0);
    cmp(rd[5], 32'h0);
    // Accumulator is 0 here; a 1 x 1 MAC leaves 1 for the next outside write
    issue(`OP_SIGNED_MAC_NOWB, 5'h00, 5'h00, 32'h00000001, 32'h00000001);
    ext_wr(5'h0b, 32'h0000dead);
    cmp(reg_we, 32'h1);
    cmp(reg_waddr, 32'hb);
    cmp(reg_wdata, 32'h00000001);
    ext_wr(5'h0c, 32'h0000beef);
    cmp(reg_wdata, 32'h0000beef);
    test_done;
  end
endmodule
`default_nettype wire
